// [bench/line_exchange.sv]
// exchange model: drives the demodulated line bit and the alerting tone
module line_exchange #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic clk_in,
  output logic line_out,
  output logic tone_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // line rests at mark between bursts
  initial begin
    line_out = 1'b1;
    tone_out = 1'b0;
  end

  task automatic bit_time(input logic v);
    @(posedge clk_in);
    #1 line_out = v;
    repeat (BIT_CYCLES - 1) @(posedge clk_in);
  endtask : bit_time

  task automatic mark(input int n);
    repeat (n) bit_time(1'b1);
  endtask : mark

  // on-hook burst, sent only in the quiet gap
  task automatic seize(input int n);
    for (int i = 0; i < n; i++) bit_time(i[0]);
  endtask : seize

  // start zero, lsb first, stop level chosen to model a damaged character
  task automatic send_frame(input logic [7:0] b, input logic stop);
    bit_time(1'b0);
    for (int i = 0; i < 8; i++) bit_time(b[i]);
    bit_time(stop);
  endtask : send_frame

  // a clean character always ends in a one stop bit
  task automatic send_byte(input logic [7:0] b);
    send_frame(b, 1'b1);
  endtask : send_byte

  task automatic tone();
    @(posedge clk_in);
    #1 tone_out = 1'b1;
    repeat (6) @(posedge clk_in);
    #1 tone_out = 1'b0;
  endtask : tone
endmodule : line_exchange

// [bench/tb.sv]
// testbench of the caller identity message parser
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BC = 16;
  localparam int AC = 20;
  logic clk, rst_n, line, tone, hook, route, gap;
  logic ack, dv, sv, multi, seized, done, err;
  logic [7:0] data, field, addr;
  logic [24:0] got[$];
  logic [24:0] exp_q[$];
  logic [7:0] body[$];
  int errors, samples_checked, done_n, err_n, ack_n, cyc, n_st;

  caller_id_message_parser #(.BIT_CYCLES(BC), .ACK_CYCLES(AC)) i_dut (
    .CLOCK_IN(clk), .RST_N_IN(rst_n), .RX_BIT_IN(line), .CAS_DETECT_IN(tone),
    .OFF_HOOK_IN(hook), .ACK_OUT(ack), .ROUTE_STORE_IN(route),
    .DISP_VALID_OUT(dv), .STORE_VALID_OUT(sv), .DATA_OUT(data),
    .FIELD_OUT(field), .ADDR_OUT(addr), .FORMAT_MULTI_OUT(multi),
    .SEIZURE_SEEN_OUT(seized), .MSG_DONE_OUT(done), .MSG_ERROR_OUT(err));

  line_exchange #(.BIT_CYCLES(BC)) i_ex (
    .clk_in(clk), .line_out(line), .tone_out(tone));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // done and error pulses stand one cycle, valid stands one cycle per released byte and ack is counted per cycle, so all are collected on every edge
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dv === 1'b1 || sv === 1'b1) got.push_back({sv, field, data, addr});
    if (done === 1'b1) done_n++;
    if (err === 1'b1) err_n++;
    if (ack === 1'b1) ack_n++;
    if (cyc == 60000) begin
      check(32'(cyc), 32'h0);
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic clear(input logic r);
    @(posedge clk);
    #1 route = r;
    got.delete();
    exp_q.delete();
    body.delete();
    done_n = 0;
    err_n = 0;
    ack_n = 0;
    n_st = 0;
  endtask : clear

  // record header bytes are sent but never released
  task automatic add_rec(input logic m, input logic [7:0] t, input logic [7:0] n,
                         input logic [7:0] s);
    if (m) begin
      body.push_back(t);
      body.push_back(n);
    end
    for (int i = 0; i < n; i++) begin
      body.push_back(s + 8'(i));
      exp_q.push_back({route, t, s + 8'(i), 8'(n_st)});
      n_st++;
    end
  endtask : add_rec

  task automatic send_msg(input logic [7:0] mt, input logic good);
    logic [7:0] sum;
    sum = mt + 8'(body.size());
    foreach (body[i]) sum = sum + body[i];
    i_ex.mark(12);
    i_ex.send_byte(mt);
    i_ex.send_byte(8'(body.size()));
    foreach (body[i]) begin
      if (gap) i_ex.mark(3);
      i_ex.send_byte(body[i]);
    end
    i_ex.send_byte(good ? 8'h00 - sum : 8'h01 - sum);
    i_ex.mark(2);
    repeat (BC) @(posedge clk);
  endtask : send_msg

  task automatic verify(input int dn, input int en);
    check(32'(done_n), 32'(dn));
    check(32'(err_n), 32'(en));
    check(32'(got.size()), 32'(exp_q.size()));
    foreach (exp_q[i]) check(32'(got[i]), 32'(exp_q[i]));
  endtask : verify

  ////////////////////////////////////////////////////////////////////////
  task automatic t_single();
    clear(1'b0);
    gap = 1'b0;
    i_ex.seize(30);
    add_rec(1'b0, 8'h00, 8'h08, 8'h30);
    send_msg(8'h04, 1'b1);
    verify(1, 0);
    check(32'(seized), 32'h1);
    check(32'(multi), 32'h0);
    $display("single format to display done");
  endtask : t_single

  task automatic t_multi();
    clear(1'b1);
    gap = 1'b1;
    add_rec(1'b1, 8'h01, 8'h08, 8'h30);
    add_rec(1'b1, 8'h07, 8'h09, 8'h20);
    add_rec(1'b1, 8'h02, 8'h00, 8'h00);
    add_rec(1'b1, 8'h02, 8'h03, 8'h39);
    send_msg(8'h80, 1'b1);
    verify(1, 0);
    check(32'(multi), 32'h1);
    $display("multiple format to storage done");
  endtask : t_multi

  task automatic t_badsum();
    clear(1'b0);
    gap = 1'b0;
    add_rec(1'b1, 8'h07, 8'h04, 8'h61);
    exp_q.delete();
    send_msg(8'h80, 1'b0);
    verify(0, 1);
    $display("bad checksum done");
  endtask : t_badsum

  task automatic t_offhook();
    clear(1'b0);
    gap = 1'b0;
    hook = 1'b1;
    add_rec(1'b0, 8'h00, 8'h04, 8'h35);
    send_msg(8'h04, 1'b1);
    check(32'(done_n), 32'h0);
    check(32'(ack_n), 32'h0);
    i_ex.tone();
    repeat (AC + 10) @(posedge clk);
    check(32'(ack_n), 32'(AC));
    send_msg(8'h04, 1'b1);
    verify(1, 0);
    #1 hook = 1'b0;
    $display("off-hook delivery done");
  endtask : t_offhook

  // broken messages: each gives one error pulse and releases nothing; a good message then gives done and is released
  task automatic t_faults();
    clear(1'b0);
    gap = 1'b0;
    // record length runs past the message length
    i_ex.mark(12);
    i_ex.send_byte(8'h80);
    i_ex.send_byte(8'h02);
    i_ex.send_byte(8'h07);
    i_ex.send_byte(8'h05);
    i_ex.mark(12);
    check(32'(err_n), 32'h1);
    // record type as last content byte
    i_ex.send_byte(8'h80);
    i_ex.send_byte(8'h01);
    i_ex.send_byte(8'h07);
    i_ex.mark(12);
    check(32'(err_n), 32'h2);
    // zero stop bit inside a message
    i_ex.send_byte(8'h04);
    i_ex.send_frame(8'h30, 1'b0);
    i_ex.mark(12);
    check(32'(err_n), 32'h3);
    check(32'(done_n), 32'h0);
    check(32'(got.size()), 32'h0);
    // next message taken after a fresh mark run
    add_rec(1'b0, 8'h00, 8'h02, 8'h31);
    send_msg(8'h04, 1'b1);
    verify(1, 3);
    $display("error frames done");
  endtask : t_faults

  initial begin
    rst_n = 1'b0;
    hook = 1'b0;
    route = 1'b0;
    gap = 1'b0;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    t_single();
    t_multi();
    t_badsum();
    t_offhook();
    t_faults();
    finish_test();
  end
endmodule : tb

// [hw/caller_id_message_parser.sv]
// caller identity message parser: bit framing, message decode, checksum and routing
// Operation
// R1 - on-hook, exchange sends data between first and second ringing bursts.
// R2 - off-hook, acknowledgment must be returned before any data is accepted.
// R3 - off-hook, exchange sends alerting tone before acknowledgment and data.
// R4 - on-hook alternating ones and zeros are preamble, never message content; once a mark run has armed it, the code frames them as characters.
// R5 - off-hook, a run of continuous ones is the start condition.
// R6 - any number of records, each type, length, then that many bytes.
// R7 - runs of ones between frames are discarded without losing sync.
// R8 - byte after the last declared content byte is the checksum.
// R9 - record data length comes from its length byte, no fixed size.
// R10 - start and stop bits are stripped; single or multiple format decided.
// R11 - each good message goes to storage or to the display output.
// R12 - single format carries date, time, number only; name only in multiple.
// R13 - multiple format record contents pass through as arbitrary characters.
// R14 - message type then length; length bounds records before checksum.
// R15 - completion flag on checksum pass, error flag on failure.
// R16 - each byte framed by start bit zero and stop bit one, no parity.
// R17 - checksum is two's complement of byte sum modulo 256.
// R18 - message type 80 hex marks the multiple record format.
// R19 - checksum mismatch withholds the message from display.
`include "cid_defines.svh"
module caller_id_message_parser #(
  parameter int BIT_CYCLES = `BIT_CYCLES,
  parameter int ACK_CYCLES = `ACK_CYCLES
) (
  // clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  // line side
  input wire logic RX_BIT_IN,
  input wire logic CAS_DETECT_IN,
  input wire logic OFF_HOOK_IN,
  output logic ACK_OUT,
  // routing select, high sends messages to storage
  input wire logic ROUTE_STORE_IN,
  // message output
  output logic DISP_VALID_OUT,
  output logic STORE_VALID_OUT,
  output logic [7:0] DATA_OUT,
  output logic [7:0] FIELD_OUT,
  output logic [7:0] ADDR_OUT,
  // status
  output logic FORMAT_MULTI_OUT,
  output logic SEIZURE_SEEN_OUT,
  output logic MSG_DONE_OUT,
  output logic MSG_ERROR_OUT
);

  cid_pkg::parser_state_t r;
  cid_pkg::parser_state_t n;
  function automatic logic [7:0] add8(input logic [7:0] a, input logic [7:0] b);
    add8 = 8'(a + b);
  endfunction : add8
  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic got_byte;
    logic frame_err;
    logic end_msg;
    logic [7:0] b;
    logic [7:0] rem_after;
    got_byte = 1'b0;
    frame_err = 1'b0;
    end_msg = 1'b0;
    b = r.shreg;
    rem_after = 8'(r.msg_remain - 8'h01);
    n = r;
    n.rx_meta = RX_BIT_IN;
    n.rx_sync = r.rx_meta;
    n.cas_meta = CAS_DETECT_IN;
    n.cas_sync = r.cas_meta;
    n.cas_prev = r.cas_sync;
    n.hook_meta = OFF_HOOK_IN;
    n.hook_sync = r.hook_meta;
    n.route_meta = ROUTE_STORE_IN;
    n.route_sync = r.route_meta;
    n.disp_valid = 1'b0;
    n.store_valid = 1'b0;
    n.msg_done = 1'b0;
    n.msg_err = 1'b0;
    if (r.bit_cnt != 16'h0000) begin
      n.bit_cnt = 16'(r.bit_cnt - 16'h0001);
    end

    // R2 acknowledge pulse while off-hook
    if (r.ack_out) begin
      n.ack_cnt = 16'(r.ack_cnt - 16'h0001);
      if (r.ack_cnt == 16'h0001) begin
        n.ack_out = 1'b0;
        n.ack_done = 1'b1;
      end
    end else if (r.hook_sync && !r.ack_done && r.cas_sync && !r.cas_prev) begin
      n.ack_out = 1'b1;
      n.ack_cnt = 16'(ACK_CYCLES);
    end
    if (!r.hook_sync) begin
      n.ack_done = 1'b0;
    end
    case (r.link)
      cid_pkg::L_HUNT: begin
        if (r.bit_cnt == 16'h0000) begin
          n.bit_cnt = 16'(BIT_CYCLES - 1);
          n.last_bit = r.rx_sync;
          // R5 count a run of continuous ones as the start condition
          if (r.rx_sync && r.ones_run != 4'hf) begin
            n.ones_run = 4'(r.ones_run + 4'h1);
          end else if (!r.rx_sync) begin
            n.ones_run = 4'h0;
          end
          if (r.ones_run >= `MARK_MIN_BITS) begin
            n.armed = 1'b1;
          end
          // R4 alternating bits are counted as preamble, and once armed a zero among them starts a character
          if (r.rx_sync != r.last_bit && r.alt_cnt != 4'hf) begin
            n.alt_cnt = 4'(r.alt_cnt + 4'h1);
          end else if (r.rx_sync == r.last_bit) begin
            n.alt_cnt = 4'h0;
          end
          if (r.alt_cnt >= `SEIZE_MIN_BITS) begin
            n.seizure_seen = 1'b1;
          end
        end
        // R2 no character is taken off-hook until acknowledged
        if (!r.rx_sync && r.armed && (!r.hook_sync || r.ack_done)) begin
          n.link = cid_pkg::L_START;
          n.bit_cnt = 16'(BIT_CYCLES / 2);
        end
      end
      cid_pkg::L_START: begin
        if (r.bit_cnt == 16'h0000) begin
          // R16 start bit must still read zero at mid bit
          if (!r.rx_sync) begin
            n.link = cid_pkg::L_DATA;
            n.bit_idx = 3'h0;
            n.bit_cnt = 16'(BIT_CYCLES - 1);
          end else begin
            n.link = cid_pkg::L_HUNT;
          end
        end
      end
      cid_pkg::L_DATA: begin
        if (r.bit_cnt == 16'h0000) begin
          // R10 only the eight data bits are kept, low bit first
          n.shreg = {r.rx_sync, r.shreg[7:1]};
          n.bit_cnt = 16'(BIT_CYCLES - 1);
          n.bit_idx = 3'(r.bit_idx + 3'h1);
          if (r.bit_idx == 3'h7) begin
            n.link = cid_pkg::L_STOP;
          end
        end
      end
      default: begin
        if (r.bit_cnt == 16'h0000) begin
          n.link = cid_pkg::L_HUNT;
          // R16 stop bit must read one
          if (r.rx_sync) begin
            got_byte = 1'b1;
          end else begin
            frame_err = 1'b1;
            n.armed = 1'b0;
            n.ones_run = 4'h0;
          end
        end
      end
    endcase
    // R7 ones between characters keep the link in hunt with sync intact
    if (frame_err && r.pst != cid_pkg::P_TYPE && r.pst != cid_pkg::P_REPLAY) begin
      n.msg_err = 1'b1;
      n.pst = cid_pkg::P_TYPE;
    end else if (got_byte) begin
      n.sum = add8(r.sum, b);
      case (r.pst)
        cid_pkg::P_TYPE: begin
          // R18 type 80 hex selects multiple record format
          // R10 format decided from the type byte
          n.multi = (b == `MULTI_TYPE);
          n.sum = b;
          n.wr_ptr = 8'h00;
          n.pst = cid_pkg::P_LEN;
        end
        cid_pkg::P_LEN: begin
          // R14 length bounds everything before the checksum
          n.msg_remain = b;
          if (b == 8'h00) begin
            n.pst = cid_pkg::P_CSUM;
          end else if (r.multi) begin
            n.pst = cid_pkg::P_PTYPE;
          end else begin
            n.pst = cid_pkg::P_SDATA;
          end
        end
        cid_pkg::P_SDATA: begin
          // R12 single format content is one untyped date, time, number body
          n.msg_buf[r.wr_ptr] = {`FIELD_SINGLE, b};
          n.wr_ptr = 8'(r.wr_ptr + 8'h01);
          n.msg_remain = rem_after;
          if (rem_after == 8'h00) begin
            n.pst = cid_pkg::P_CSUM;
          end
        end
        cid_pkg::P_PTYPE: begin
          // R6 record opens with its type byte
          n.field = b;
          n.msg_remain = rem_after;
          if (rem_after == 8'h00) begin
            end_msg = 1'b1;
            n.msg_err = 1'b1;
            n.pst = cid_pkg::P_TYPE;
          end else begin
            n.pst = cid_pkg::P_PLEN;
          end
        end
        cid_pkg::P_PLEN: begin
          // R9 record data length taken from its length byte
          n.par_remain = b;
          n.msg_remain = rem_after;
          if (b > rem_after) begin
            end_msg = 1'b1;
            n.msg_err = 1'b1;
            n.pst = cid_pkg::P_TYPE;
          end else if (b != 8'h00) begin
            n.pst = cid_pkg::P_PDATA;
          end else if (rem_after == 8'h00) begin
            n.pst = cid_pkg::P_CSUM;
          end else begin
            n.pst = cid_pkg::P_PTYPE;
          end
        end
        cid_pkg::P_PDATA: begin
          // R13 record bytes pass untouched, tagged with the record type
          n.msg_buf[r.wr_ptr] = {r.field, b};
          n.wr_ptr = 8'(r.wr_ptr + 8'h01);
          n.msg_remain = rem_after;
          n.par_remain = 8'(r.par_remain - 8'h01);
          // R6 next record follows while length remains
          if (rem_after == 8'h00) begin
            n.pst = cid_pkg::P_CSUM;
          end else if (r.par_remain == 8'h01) begin
            n.pst = cid_pkg::P_PTYPE;
          end
        end
        cid_pkg::P_CSUM: begin
          end_msg = 1'b1;
          // R8 byte after the declared content is the checksum
          // R17 a good message sums to zero modulo 256
          // R15 completion or error flag
          if (add8(r.sum, b) == 8'h00) begin
            n.msg_done = 1'b1;
            n.rd_ptr = 8'h00;
            n.pst = (r.wr_ptr != 8'h00) ? cid_pkg::P_REPLAY : cid_pkg::P_TYPE;
          end else begin
            n.msg_err = 1'b1;
            n.pst = cid_pkg::P_TYPE;
          end
        end
        default: begin
          n.pst = r.pst;
        end
      endcase
    end
    // R19 content is released only after the checksum has passed
    // R11 released bytes go to storage or to display
    if (r.pst == cid_pkg::P_REPLAY) begin
      n.out_data = r.msg_buf[r.rd_ptr][7:0];
      n.out_field = r.msg_buf[r.rd_ptr][15:8];
      n.out_addr = r.rd_ptr;
      n.store_valid = r.route_sync;
      n.disp_valid = !r.route_sync;
      n.rd_ptr = 8'(r.rd_ptr + 8'h01);
      if (8'(r.rd_ptr + 8'h01) == r.wr_ptr) begin
        n.pst = cid_pkg::P_TYPE;
      end
    end
    // a fresh mark run is needed before the next message; acknowledgment is spent
    if (end_msg) begin
      n.armed = 1'b0;
      n.ones_run = 4'h0;
      n.ack_done = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  assign ACK_OUT = r.ack_out;
  assign DISP_VALID_OUT = r.disp_valid;
  assign STORE_VALID_OUT = r.store_valid;
  assign DATA_OUT = r.out_data;
  assign FIELD_OUT = r.out_field;
  assign ADDR_OUT = r.out_addr;
  assign FORMAT_MULTI_OUT = r.multi;
  assign SEIZURE_SEEN_OUT = r.seizure_seen;
  assign MSG_DONE_OUT = r.msg_done;
  assign MSG_ERROR_OUT = r.msg_err;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  sequence seq_byte;
    r.link == cid_pkg::L_STOP && r.bit_cnt == 16'h0000 && r.rx_sync;
  endsequence
  sequence seq_enter_start;
    r.link == cid_pkg::L_START && $past(r.link) == cid_pkg::L_HUNT;
  endsequence
  AST_FLAGS_EXCLUSIVE: assert property (!(r.msg_done && r.msg_err)) // R15
    else $error("done and error flags together");
  AST_DISPLAY_AFTER_PASS: assert property ($rose(r.disp_valid) |-> $past(r.msg_done)) // R19
    else $error("display output without a passed checksum");
  AST_START_NEEDS_ACK: assert property (seq_enter_start |->
      (!$past(r.hook_sync) || $past(r.ack_done))) // R2
    else $error("character taken off-hook before acknowledgment");
  AST_ACK_HOLDS: assert property ($rose(r.ack_out) |-> r.ack_out [*8]) // R2
    else $error("acknowledgment pulse too short");
  AST_START_NEEDS_MARK: assert property (seq_enter_start |-> $past(r.armed)) // R5
    else $error("character start without a mark run");
  AST_BAD_STOP: assert property (r.link == cid_pkg::L_STOP && r.bit_cnt == 16'h0000 &&
      !r.rx_sync |=> r.link == cid_pkg::L_HUNT && !r.armed) // R16
    else $error("bad stop bit not rejected");
  AST_MULTI_TYPE: assert property (seq_byte and r.pst == cid_pkg::P_TYPE |=>
      r.multi == (r.shreg == `MULTI_TYPE)) // R18
    else $error("format flag does not follow the type byte");
  AST_CHECKSUM: assert property (seq_byte and r.pst == cid_pkg::P_CSUM |=>
      r.msg_done == (add8($past(r.sum), $past(r.shreg)) == 8'h00)) // R17
    else $error("checksum verdict wrong");
  AST_SINGLE_FIELD: assert property (r.disp_valid && !r.multi |->
      r.out_field == `FIELD_SINGLE) // R12
    else $error("single format byte carries a record type");
  AST_RECORD_BOUND: assert property (seq_byte and r.pst == cid_pkg::P_PLEN and
      r.shreg > 8'(r.msg_remain - 8'h01) |=> r.msg_err) // R9
    else $error("record longer than message not flagged");
endmodule : caller_id_message_parser

// [hw/cid_defines.svh]
// timing, field and encoding constants of the caller identity message parser
`ifndef CID_DEFINES_SVH
`define CID_DEFINES_SVH

`define CLOCK_HZ 10000000
`define BAUD_RATE 1200
`define BIT_CYCLES (`CLOCK_HZ / `BAUD_RATE)
`define ACK_TIME_US 1000
`define ACK_CYCLES ((`CLOCK_HZ / 1000000) * `ACK_TIME_US)
`define MARK_MIN_BITS 4'ha
`define SEIZE_MIN_BITS 4'hc
`define MULTI_TYPE 8'h80
`define FIELD_SINGLE 8'h00
`define BUF_DEPTH 256

`endif

// [hw/cid_pkg.sv]
// types of the caller identity message parser
package cid_pkg;

  typedef enum logic [1:0] {
    L_HUNT,
    L_START,
    L_DATA,
    L_STOP
  } link_state_t;

  typedef enum logic [2:0] {
    P_TYPE,
    P_LEN,
    P_SDATA,
    P_PTYPE,
    P_PLEN,
    P_PDATA,
    P_CSUM,
    P_REPLAY
  } parse_state_t;

  typedef struct packed {
    logic rx_meta;
    logic rx_sync;
    logic cas_meta;
    logic cas_sync;
    logic cas_prev;
    logic hook_meta;
    logic hook_sync;
    logic route_meta;
    logic route_sync;
    link_state_t link;
    logic [15:0] bit_cnt;
    logic [2:0] bit_idx;
    logic [7:0] shreg;
    logic [3:0] ones_run;
    logic [3:0] alt_cnt;
    logic last_bit;
    logic armed;
    logic seizure_seen;
    logic ack_done;
    logic [15:0] ack_cnt;
    logic ack_out;
    parse_state_t pst;
    logic multi;
    logic [7:0] msg_remain;
    logic [7:0] par_remain;
    logic [7:0] field;
    logic [7:0] sum;
    logic [7:0] wr_ptr;
    logic [7:0] rd_ptr;
    logic [255:0][15:0] msg_buf;
    logic disp_valid;
    logic store_valid;
    logic [7:0] out_data;
    logic [7:0] out_field;
    logic [7:0] out_addr;
    logic msg_done;
    logic msg_err;
  } parser_state_t;

endpackage : cid_pkg
